// [rtl/host_uart_byte_flow_control.sv]
// How it works
// - 9600 b/s port, byte and packet pacing
// - Pending low until host ready or timeout
// - On timeout release, wait, then retry
// - Release pending within 10 ms of ready
// - Each next byte waits for ready re-fall
// - Start bit within 10 ms of ready
// - Accept output high until network joined
// - Accept high when full or not joined
// - Local packets received regardless of accept
// - Timestamp input low requests timestamp packet
// - Receive tolerates 2 percent, transmit 1 percent
// - One stop bit each direction
// - Answer every request within 125 ms
// - Twenty ms gap between packets
// - Eight data bits, no parity
`default_nettype none
module host_uart_byte_flow_control #(
	parameter int PENDING_WAIT_CYC = host_uart_pkg::PENDING_WAIT_CYC,
	parameter int RETRY_WAIT_CYC   = host_uart_pkg::RETRY_WAIT_CYC,
	parameter int INTERPACKET_CYC  = host_uart_pkg::INTERPACKET_CYC,
	parameter int RESPONSE_CYC     = host_uart_pkg::RESPONSE_CYC,
	parameter int FIFO_DEPTH       = host_uart_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       arst_n,
	// Serial link
	input  wire logic       uartRx,
	output logic            uartTx,
	output logic            packet_pending_n,
	input  wire logic       host_ready_n,
	output logic            accept_packet_n,
	input  wire logic       timestamp_n,
	// Device side: bytes toward host, last marks end of packet
	input  wire logic       txValid,
	output logic            txReady,
	input  wire logic [7:0] txData,
	input  wire logic       txLast,
	// Device side: bytes from host
	output logic            rxValid,
	output logic [7:0]      rxData,
	output logic            rxFrameError,
	// Device status and events
	input  wire logic       netJoined,
	input  wire logic       bufferSpace,
	output logic            timestampReq,
	output logic            responseLate
);
	typedef enum logic [2:0] {
		TX_IDLE, TX_GAP, TX_PEND, TX_RETRY, TX_WAIT_LOW, TX_SHIFT, TX_WAIT_HIGH
	} tx_mode_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_mode_t;

	typedef struct packed {
		logic [1:0]  readySync;
		logic [1:0]  stampSync;
		logic [1:0]  rxSync;
		logic        stampPrev;
		logic        stampPulse;
		tx_mode_t    txMode;
		logic [23:0] txTimer;
		logic [15:0] txBaud;
		logic [3:0]  txBit;
		logic [9:0]  txShift;
		logic        txLastByte;
		logic        ackSeen;
		logic        pending;
		logic        line;
		rx_mode_t    rxMode;
		logic [15:0] rxBaud;
		logic [3:0]  rxBit;
		logic [7:0]  rxShift;
		logic        rxValid;
		logic [7:0]  rxData;
		logic        rxErr;
		logic [23:0] respTimer;
		logic        respOpen;
		logic        late;
	} state_t;
	state_t st_reg, st_next;

	logic       fifoValid, fifoPop;
	logic [8:0] fifoData;
	logic       readyLow, stampLow, rxLine;

	// Outbound bytes queue here; txReady stalls the device source when full
	byte_fifo #(.WIDTH(host_uart_pkg::FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock    (clock),
		.arst_n   (arst_n),
		.inValid  (txValid),
		.inReady  (txReady),
		.inData   ({txLast, txData}),
		.outValid (fifoValid),
		.outReady (fifoPop),
		.outData  (fifoData)
	);

	assign readyLow = !st_reg.readySync[1];
	assign stampLow = !st_reg.stampSync[1];
	assign rxLine   = st_reg.rxSync[1];

	// Outputs straight from state, except accept_packet_n decoded from netJoined and bufferSpace
	assign uartTx           = st_reg.line;
	assign packet_pending_n = !st_reg.pending;
	assign accept_packet_n  = !(netJoined && bufferSpace);
	assign rxValid          = st_reg.rxValid;
	assign rxData           = st_reg.rxData;
	assign rxFrameError     = st_reg.rxErr;
	assign timestampReq     = st_reg.stampPulse;
	assign responseLate     = st_reg.late;

	// Next-state logic for synchronisers, transmitter, receiver and timers
	always_comb begin
		st_next = st_reg;
		fifoPop = 1'b0;
		// Two-stage synchronisers on host inputs
		st_next.readySync = {st_reg.readySync[0], host_ready_n};
		st_next.stampSync = {st_reg.stampSync[0], timestamp_n};
		st_next.rxSync    = {st_reg.rxSync[0], uartRx};
		// Timestamp request on falling edge of synchronised input
		st_next.stampPrev  = stampLow;
		st_next.stampPulse = stampLow && !st_reg.stampPrev;
		st_next.rxValid    = 1'b0;

		// Transmit path
		case (st_reg.txMode)
			TX_IDLE: begin
				if (fifoValid) begin
					st_next.pending = 1'b1;
					st_next.txTimer = '0;
					st_next.txMode  = TX_PEND;
				end
			end
			TX_GAP: begin
				st_next.txTimer = st_reg.txTimer + 1'b1;
				if (st_reg.txTimer >= 24'(INTERPACKET_CYC - 1)) st_next.txMode = TX_IDLE;
			end
			TX_PEND: begin
				st_next.txTimer = st_reg.txTimer + 1'b1;
				if (readyLow) begin
					st_next.pending = 1'b0;
					st_next.txMode  = TX_WAIT_LOW;
				end else if (st_reg.txTimer >= 24'(PENDING_WAIT_CYC - 1)) begin
					st_next.pending = 1'b0;
					st_next.txTimer = '0;
					st_next.txMode  = TX_RETRY;
				end
			end
			TX_RETRY: begin
				st_next.txTimer = st_reg.txTimer + 1'b1;
				if (st_reg.txTimer >= 24'(RETRY_WAIT_CYC - 1)) begin
					st_next.pending = 1'b1;
					st_next.txTimer = '0;
					st_next.txMode  = TX_PEND;
				end
			end
			TX_WAIT_LOW: begin
				// Ready seen low: start the byte at once
				if (readyLow && fifoValid) begin
					fifoPop            = 1'b1;
					st_next.txShift    = {1'b1, fifoData[7:0], 1'b0};
					st_next.txLastByte = fifoData[8];
					st_next.ackSeen    = 1'b0;
					st_next.txBit      = '0;
					st_next.txBaud     = '0;
					st_next.line       = 1'b0;
					st_next.txMode     = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				// Host may raise ready while the byte is still going out
				if (!readyLow) st_next.ackSeen = 1'b1;
				st_next.txBaud = st_reg.txBaud + 1'b1;
				if (st_reg.txBaud == 16'(host_uart_pkg::BIT_CYCLES - 1)) begin
					st_next.txBaud = '0;
					st_next.txBit  = st_reg.txBit + 1'b1;
					if (st_reg.txBit == 4'(host_uart_pkg::DATA_BITS + 1)) begin
						st_next.line    = 1'b1;
						st_next.txTimer = '0;
						if (st_reg.txLastByte) st_next.txMode = TX_GAP;
						else if (st_reg.ackSeen || !readyLow) st_next.txMode = TX_WAIT_LOW;
						else st_next.txMode = TX_WAIT_HIGH;
					end else begin
						st_next.line = st_reg.txShift[st_reg.txBit + 4'd1];
					end
				end
			end
			TX_WAIT_HIGH: begin
				// Next byte only after ready rises and falls again
				if (!readyLow) st_next.txMode = TX_WAIT_LOW;
			end
			default: st_next.txMode = TX_IDLE;
		endcase

		// Receive path, sampled mid-bit; all packets taken, local or not
		case (st_reg.rxMode)
			RX_IDLE: begin
				st_next.rxBaud = '0;
				if (!rxLine) st_next.rxMode = RX_START;
			end
			RX_START: begin
				st_next.rxBaud = st_reg.rxBaud + 1'b1;
				if (st_reg.rxBaud == 16'(host_uart_pkg::HALF_BIT_CYCLES - 1)) begin
					st_next.rxBaud = '0;
					st_next.rxBit  = '0;
					st_next.rxMode = rxLine ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				st_next.rxBaud = st_reg.rxBaud + 1'b1;
				if (st_reg.rxBaud == 16'(host_uart_pkg::BIT_CYCLES - 1)) begin
					st_next.rxBaud  = '0;
					st_next.rxShift = {rxLine, st_reg.rxShift[7:1]};
					st_next.rxBit   = st_reg.rxBit + 1'b1;
					if (st_reg.rxBit == 4'(host_uart_pkg::DATA_BITS - 1)) st_next.rxMode = RX_STOP;
				end
			end
			RX_STOP: begin
				st_next.rxBaud = st_reg.rxBaud + 1'b1;
				if (st_reg.rxBaud == 16'(host_uart_pkg::BIT_CYCLES - 1)) begin
					st_next.rxValid = 1'b1;
					st_next.rxData  = st_reg.rxShift;
					st_next.rxErr   = !rxLine;
					st_next.rxMode  = RX_IDLE;
				end
			end
			default: st_next.rxMode = RX_IDLE;
		endcase

		// Response watchdog: a flag byte from the host opens a request
		if (st_reg.rxValid && st_reg.rxData == host_uart_pkg::HDLC_FLAG && !st_reg.respOpen) begin
			st_next.respOpen  = 1'b1;
			st_next.respTimer = '0;
		end else if (st_reg.respOpen) begin
			st_next.respTimer = st_reg.respTimer + 1'b1;
			if (fifoPop) st_next.respOpen = 1'b0;
			else if (st_reg.respTimer >= 24'(RESPONSE_CYC - 1)) begin
				st_next.late     = 1'b1;
				st_next.respOpen = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_reg           <= '0;
			st_reg.readySync <= 2'h3;
			st_reg.stampSync <= 2'h3;
			st_reg.rxSync    <= 2'h3;
			st_reg.stampPrev <= 1'b0;
			st_reg.line      <= 1'b1;
			st_reg.txMode    <= TX_IDLE;
			st_reg.rxMode    <= RX_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// Pending released one cycle after synchronised ready low
	property p_pendRelease;
		@(posedge clock) disable iff (!arst_n)
		(st_reg.txMode == TX_PEND && readyLow) |=> packet_pending_n;
	endproperty
	a_pendRelease: assert property (p_pendRelease) else $error("pending not released");

	// Start bit follows ready low immediately
	sequence s_startReady;
		st_reg.txMode == TX_WAIT_LOW && readyLow && fifoValid;
	endsequence
	property p_startBit;
		@(posedge clock) disable iff (!arst_n)
		s_startReady |=> !uartTx && st_reg.txMode == TX_SHIFT;
	endproperty
	a_startBit: assert property (p_startBit) else $error("start bit late");

	// Start bit stays low for at least eight cycles
	property p_bitLen;
		@(posedge clock) disable iff (!arst_n)
		$fell(uartTx) |-> !uartTx [*8];
	endproperty
	a_bitLen: assert property (p_bitLen) else $error("start bit too short");

	// Pending never shown while waiting for retry
	property p_retryQuiet;
		@(posedge clock) disable iff (!arst_n)
		st_reg.txMode == TX_RETRY |-> packet_pending_n;
	endproperty
	a_retryQuiet: assert property (p_retryQuiet) else $error("pending during retry");

	// Pending low while offering a packet
	property p_pendHold;
		@(posedge clock) disable iff (!arst_n)
		(st_reg.txMode == TX_PEND && !readyLow) |=> (!packet_pending_n || st_reg.txMode == TX_RETRY);
	endproperty
	a_pendHold: assert property (p_pendHold) else $error("pending dropped early");

	// No new byte while ready still low after a byte
	property p_byteWait;
		@(posedge clock) disable iff (!arst_n)
		st_reg.txMode == TX_WAIT_HIGH |=> uartTx;
	endproperty
	a_byteWait: assert property (p_byteWait) else $error("byte started without ack");

	// Accept high while not joined
	property p_accept;
		@(posedge clock) disable iff (!arst_n)
		!netJoined |-> accept_packet_n;
	endproperty
	a_accept: assert property (p_accept) else $error("accept while not joined");

	// Accept high when buffer full
	property p_acceptFull;
		@(posedge clock) disable iff (!arst_n)
		!bufferSpace |-> accept_packet_n;
	endproperty
	a_acceptFull: assert property (p_acceptFull) else $error("accept without space");

	// Timestamp pulse follows synchronised falling edge
	property p_stamp;
		@(posedge clock) disable iff (!arst_n)
		$fell(timestamp_n) |-> ##3 timestampReq;
	endproperty
	a_stamp: assert property (p_stamp) else $error("timestamp not raised");
endmodule : host_uart_byte_flow_control
`default_nettype wire

// [rtl/host_uart_pkg.sv]
`default_nettype none
package host_uart_pkg;
	localparam int CLOCK_HZ          = 20_000_000;
	localparam int BAUD_RATE         = 9600;
	// Bit period rounded to nearest; error well under 1 percent
	localparam int BIT_CYCLES        = (CLOCK_HZ + BAUD_RATE / 2) / BAUD_RATE;
	localparam int HALF_BIT_CYCLES   = BIT_CYCLES / 2;
	localparam int DATA_BITS         = 8;
	// Handshake timing in ms
	localparam int PENDING_WAIT_MS   = 500;
	localparam int RETRY_WAIT_MS     = 500;
	localparam int INTERPACKET_MS    = 20;
	localparam int RESPONSE_MS       = 125;
	localparam int PENDING_WAIT_CYC  = PENDING_WAIT_MS * (CLOCK_HZ / 1000);
	localparam int RETRY_WAIT_CYC    = RETRY_WAIT_MS * (CLOCK_HZ / 1000);
	localparam int INTERPACKET_CYC   = INTERPACKET_MS * (CLOCK_HZ / 1000);
	localparam int RESPONSE_CYC      = RESPONSE_MS * (CLOCK_HZ / 1000);
	localparam int FIFO_DEPTH        = 32;
	localparam int FIFO_WIDTH        = 9;
	localparam logic [7:0] HDLC_FLAG = 8'h7E;
endpackage : host_uart_pkg
`default_nettype wire

// [rtl/byte_fifo.sv]
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             arst_n,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0]   count;
	} fifo_state_t;
	fifo_state_t st_reg, st_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic pushing, popping;

	// Handshakes and pointer updates
	always_comb begin
		inReady  = (st_reg.count != (AW+1)'(DEPTH));
		outValid = (st_reg.count != '0);
		outData  = mem[st_reg.rdPtr];
		pushing  = inValid && inReady;
		popping  = outValid && outReady;
		st_next  = st_reg;
		if (pushing) st_next.wrPtr = st_reg.wrPtr + 1'b1;
		if (popping) st_next.rdPtr = st_reg.rdPtr + 1'b1;
		if (pushing && !popping) st_next.count = st_reg.count + 1'b1;
		else if (popping && !pushing) st_next.count = st_reg.count - 1'b1;
	end

	// State register
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) st_reg <= '0;
		else st_reg <= st_next;
	end

	// Storage array
	always_ff @(posedge clock) begin
		if (pushing) mem[st_reg.wrPtr] <= inData;
	end
endmodule : byte_fifo
`default_nettype wire

// [verif/host_model.sv]
`default_nettype none
module host_model #(
	parameter int BIT = host_uart_pkg::BIT_CYCLES
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       arst_n,
	// Serial link
	input  wire logic       uartTx,
	input  wire logic       packet_pending_n,
	output logic            host_ready_n,
	// Bench side
	input  wire logic       enable,
	output logic            gotByte,
	output logic [7:0]      byteData,
	output logic            stopError
);
	timeunit 1ns;
	timeprecision 1ps;

	// Take bytes until the device stops offering them
	task automatic serveBytes();
		int w;
		logic [7:0] d;
		host_ready_n <= 1'b0;
		forever begin
			w = 0;
			// Next start bit may come up to two bit periods after the ack
			while (uartTx === 1'b1 && w < 2 * BIT) begin
				@(posedge clock);
				w++;
			end
			if (w >= 2 * BIT)
				break;
			repeat (BIT / 2) @(posedge clock);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clock);
				d[i] = uartTx;
			end
			repeat (BIT) @(posedge clock);
			stopError <= !uartTx;
			byteData <= d;
			gotByte <= 1'b1;
			@(posedge clock);
			gotByte <= 1'b0;
			host_ready_n <= 1'b1;
			repeat (20) @(posedge clock);
			host_ready_n <= 1'b0;
		end
		host_ready_n <= 1'b1;
	endtask : serveBytes

	// Answer a pending packet only while enabled
	initial begin
		host_ready_n = 1'b1;
		gotByte = 1'b0;
		byteData = 8'h00;
		stopError = 1'b0;
		forever begin
			@(posedge clock);
			if (arst_n && enable && !packet_pending_n)
				serveBytes();
		end
	end
endmodule : host_model
`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none
`define CHECK(got, exp) begin nChecks++; if ((got) !== (exp)) begin failCount++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT = host_uart_pkg::BIT_CYCLES;
	logic       clock, arst_n, uartRx, uartTx, packet_pending_n, host_ready_n;
	logic       accept_packet_n, timestamp_n, txValid, txReady, txLast, rxValid;
	logic       rxFrameError, netJoined, bufferSpace, timestampReq, responseLate;
	logic       hostEnable, hostGot, hostStop;
	logic [7:0] txData, rxData, hostByte, lastRx;
	logic [7:0] rxQ[$];
	int         failCount, nChecks;
	int         rxCount = 0;

	host_uart_byte_flow_control #(.PENDING_WAIT_CYC(200), .RETRY_WAIT_CYC(200),
		.INTERPACKET_CYC(50), .RESPONSE_CYC(5000), .FIFO_DEPTH(32)) dut (
		.clock(clock), .arst_n(arst_n), .uartRx(uartRx), .uartTx(uartTx),
		.packet_pending_n(packet_pending_n), .host_ready_n(host_ready_n),
		.accept_packet_n(accept_packet_n), .timestamp_n(timestamp_n),
		.txValid(txValid), .txReady(txReady), .txData(txData), .txLast(txLast),
		.rxValid(rxValid), .rxData(rxData), .rxFrameError(rxFrameError),
		.netJoined(netJoined), .bufferSpace(bufferSpace),
		.timestampReq(timestampReq), .responseLate(responseLate));

	host_model host (.clock(clock), .arst_n(arst_n), .uartTx(uartTx),
		.packet_pending_n(packet_pending_n), .host_ready_n(host_ready_n),
		.enable(hostEnable), .gotByte(hostGot), .byteData(hostByte), .stopError(hostStop));

	// Clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Collect bytes on both sides
	always @(posedge clock) begin
		if (hostGot)
			rxQ.push_back(hostByte);
		if (rxValid) begin
			lastRx <= rxData;
			rxCount <= rxCount + 1;
		end
	end

	task automatic finalReport();
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finalReport

	task automatic timedOut(input int w, input int bound);
		if (w >= bound) begin
			failCount++;
			$display("wrong value at %0t: got %0h expected %0h", $time, w, bound);
			finalReport();
		end
	endtask : timedOut

	// Offer one byte; txValid stays up for the caller to drop
	task automatic pushByte(input logic [7:0] d, input logic last);
		int w;
		w = 0;
		txValid = 1'b1;
		txData = d;
		txLast = last;
		while (txReady !== 1'b1 && w < 100) begin
			@(negedge clock);
			w++;
		end
		timedOut(w, 100);
		@(negedge clock);
	endtask : pushByte

	task automatic testAccept();
		for (int i = 0; i < 4; i++) begin
			{netJoined, bufferSpace} = i[1:0];
			@(negedge clock);
			`CHECK(accept_packet_n, !(netJoined && bufferSpace))
		end
		$display("test accept done");
	endtask : testAccept

	task automatic testRetry();
		int w;
		pushByte(8'hA5, 1'b0);
		pushByte(8'h3C, 1'b1);
		txValid = 1'b0;
		w = 0;
		while (packet_pending_n !== 1'b0 && w < 50) begin
			@(negedge clock);
			w++;
		end
		timedOut(w, 50);
		repeat (190) @(negedge clock);
		`CHECK(packet_pending_n, 1'b0)
		repeat (20) @(negedge clock);
		`CHECK(packet_pending_n, 1'b1)
		repeat (200) @(negedge clock);
		`CHECK(packet_pending_n, 1'b0)
		$display("test retry done");
	endtask : testRetry

	task automatic testTransfer();
		int w;
		hostEnable = 1'b1;
		w = 0;
		while (rxQ.size() < 2 && w < 60000) begin
			@(negedge clock);
			w++;
		end
		timedOut(w, 60000);
		`CHECK(rxQ[0], 8'hA5)
		`CHECK(rxQ[1], 8'h3C)
		`CHECK(hostStop, 1'b0)
		`CHECK(packet_pending_n, 1'b1)
		hostEnable = 1'b0;
		$display("test transfer done");
	endtask : testTransfer

	task automatic testReceive();
		int w;
		logic [7:0] b;
		b = 8'h7E;
		`CHECK(accept_packet_n, 1'b1)
		uartRx = 1'b0;
		repeat (BIT) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			uartRx = b[i];
			repeat (BIT) @(negedge clock);
		end
		uartRx = 1'b1;
		w = 0;
		while (rxCount == 0 && w < BIT) begin
			@(negedge clock);
			w++;
		end
		timedOut(w, BIT);
		`CHECK(lastRx, 8'h7E)
		`CHECK(rxFrameError, 1'b0)
		`CHECK(responseLate, 1'b0)
		repeat (5200) @(negedge clock);
		`CHECK(responseLate, 1'b1)
		$display("test receive done");
	endtask : testReceive

	task automatic testTimestamp();
		int w;
		timestamp_n = 1'b0;
		w = 0;
		while (timestampReq !== 1'b1 && w < 8) begin
			@(negedge clock);
			w++;
		end
		`CHECK(timestampReq, 1'b1)
		timestamp_n = 1'b1;
		$display("test timestamp done");
	endtask : testTimestamp

	task automatic testFill();
		arst_n = 1'b0;
		repeat (2) @(negedge clock);
		arst_n = 1'b1;
		for (int i = 0; i < 32; i++)
			pushByte(8'(i), 1'(i == 31));
		`CHECK(txReady, 1'b0)
		txValid = 1'b0;
		$display("test fill done");
	endtask : testFill

	// Main sequence
	initial begin
		failCount = 0;
		nChecks = 0;
		arst_n = 1'b0;
		uartRx = 1'b1;
		timestamp_n = 1'b1;
		txValid = 1'b0;
		txData = 8'h00;
		txLast = 1'b0;
		netJoined = 1'b0;
		bufferSpace = 1'b0;
		hostEnable = 1'b0;
		repeat (4) @(negedge clock);
		arst_n = 1'b1;
		testAccept();
		netJoined = 1'b0;
		bufferSpace = 1'b1;
		testRetry();
		testTransfer();
		testReceive();
		testTimestamp();
		testFill();
		finalReport();
	end
endmodule : tb_top
`default_nettype wire
